// >>> twe_pkg.sv
// shared constants and types of the two-wire eeprom write path
package twe_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int PAGE_BYTES = 4;
	localparam int MEM_WORDS = 128;
	localparam int CLK_PERIOD_NS = 4;
	localparam int PROG_TIME_MS = 10;
	// longest time, so the count rounds down
	localparam int PROG_CYCLES = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam logic [7:0] MEM_RESET = 8'hff;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic RW_READ = 1'b1;
	localparam int SCL_I = 0;
	localparam int SDA_I = 1;
	localparam int WG_I = 2;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_DATA,
		ST_DATA_ACK,
		ST_PROG
	} twe_state_t;
endpackage

// >>> twe_eeprom_slave.sv
// two-wire eeprom slave: addressing, byte and page write, self-timed program cycle
// Notes on behaviour
// - eighth bit gives direction: one means read, zero means write.
// - device pulls data low through the ninth clock to acknowledge the address.
// - on a write direction, acknowledge address then wait for a data byte.
// - guard high from START to address end blocks data acks and memory change.
// - byte write is one data byte, acknowledged, then STOP from master.
// - page write latches up to four bytes sharing row select bits.
// - in page write every received data byte is acknowledged until STOP.
// - only the two low address bits step after each byte, wrapping in row.
// - STOP after a write starts the self-timed program cycle.
// - during the program cycle all bus inputs are ignored.
// - START is data falling with clock high; STOP is data rising with clock high.
// - data is sampled on the rising clock edge; master changes it while low.
// - polling during the program cycle gets no acknowledge.
`timescale 1ns/100ps
module twe_eeprom_slave #(
	parameter int PROG_CYCLES = twe_pkg::PROG_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic sclClk,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic writeGuard,
	input wire logic [twe_pkg::ADDR_W-1:0] peekAddr,
	output logic sdaOut,
	output logic sdaOe,
	output logic progBusy,
	output logic [twe_pkg::DATA_W-1:0] peekData
);
	import twe_pkg::*;

	if (PROG_CYCLES < 1) begin : g_chk
		$error("PROG_CYCLES must be at least one");
	end

	// ************************************************
	// link clock domain
	// ************************************************
	logic capBit_q;
	logic capTgl_q;

	// the bus clock may stand still through reset, so reset reaches this domain
	// asynchronously; release it only while the bus is idle
	always_ff @(posedge sclClk or posedge sys_rst) begin
		if (sys_rst) begin
			capBit_q <= 1'b1;
			capTgl_q <= 1'b0;
		end else begin
			capBit_q <= sdaIn;
			capTgl_q <= ~capTgl_q;
		end
	end

	// ************************************************
	// pin synchronisers and condition detect
	// ************************************************
	logic [2:0] syncA_q, syncB_q, syncC_q, filt_q, filtPrev_q;
	logic [2:0] tgl_q;
	logic riseEv, fallEv, startEv, stopEv;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// same idle levels as the filter, so no false edge follows reset
			syncA_q <= 3'h3;
			syncB_q <= 3'h3;
			syncC_q <= 3'h3;
			filt_q <= 3'h3;
			filtPrev_q <= 3'h3;
		end else begin
			syncA_q <= {writeGuard, sdaIn, sclIn};
			syncB_q <= syncA_q;
			syncC_q <= syncB_q;
			for (int i = 0; i < 3; i++) begin
				if (syncB_q[i] == syncC_q[i]) begin
					filt_q[i] <= syncC_q[i];
				end
			end
			filtPrev_q <= filt_q;
		end
	end

	// the captured bit is held for a whole bus clock, far longer than this crossing
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tgl_q <= 3'h0;
		end else begin
			tgl_q <= {tgl_q[1:0], capTgl_q};
		end
	end

	assign riseEv = tgl_q[1] ^ tgl_q[2];
	assign fallEv = filtPrev_q[SCL_I] & ~filt_q[SCL_I];
	assign startEv = filtPrev_q[SCL_I] & filt_q[SCL_I] & filtPrev_q[SDA_I] & ~filt_q[SDA_I];
	assign stopEv = filtPrev_q[SCL_I] & filt_q[SCL_I] & ~filtPrev_q[SDA_I] & filt_q[SDA_I];

	// ************************************************
	// protocol engine
	// ************************************************
	twe_state_t state_q;
	logic [3:0] bitCnt_q;
	logic [7:0] shift_q;
	logic [ADDR_W-1:0] addr_q;
	logic rwBit_q;
	logic guardSeen_q;
	logic sdaOe_q;
	logic [PAGE_BYTES-1:0] pageMask_q;
	logic [DATA_W-1:0] pageData_q [PAGE_BYTES];
	logic [31:0] progCnt_q;
	logic progDone;

	assign progDone = (progCnt_q == 32'(PROG_CYCLES - 1));

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			bitCnt_q <= 4'h0;
			shift_q <= 8'h00;
			addr_q <= 7'h00;
			rwBit_q <= 1'b0;
			guardSeen_q <= 1'b0;
			sdaOe_q <= 1'b0;
			pageMask_q <= '0;
			progCnt_q <= 32'h0;
			for (int i = 0; i < PAGE_BYTES; i++) begin
				pageData_q[i] <= MEM_RESET;
			end
		end else if (state_q == ST_PROG) begin
			// bus is deaf here, so polls see no acknowledge
			sdaOe_q <= 1'b0;
			if (progDone) begin
				state_q <= ST_IDLE;
				progCnt_q <= 32'h0;
			end else begin
				progCnt_q <= progCnt_q + 32'h1;
			end
		end else if (startEv) begin
			state_q <= ST_ADDR;
			bitCnt_q <= 4'h0;
			guardSeen_q <= filt_q[WG_I];
			sdaOe_q <= 1'b0;
			pageMask_q <= '0;
		end else if (stopEv) begin
			sdaOe_q <= 1'b0;
			bitCnt_q <= 4'h0;
			if ((state_q == ST_DATA || state_q == ST_DATA_ACK) && |pageMask_q && !guardSeen_q) begin
				state_q <= ST_PROG;
				progCnt_q <= 32'h0;
			end else begin
				state_q <= ST_IDLE;
			end
		end else begin
			if (state_q == ST_ADDR && filt_q[WG_I]) begin
				guardSeen_q <= 1'b1;
			end
			unique case (state_q)
				ST_IDLE, ST_PROG: begin
				end
				ST_ADDR, ST_DATA: begin
					if (riseEv && bitCnt_q < BITS_PER_BYTE) begin
						shift_q <= {shift_q[6:0], capBit_q};
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (fallEv && bitCnt_q == BITS_PER_BYTE) begin
						bitCnt_q <= 4'h0;
						if (state_q == ST_ADDR) begin
							addr_q <= shift_q[7:1];
							rwBit_q <= shift_q[0];
							sdaOe_q <= 1'b1;
							state_q <= ST_ADDR_ACK;
						end else begin
							state_q <= ST_DATA_ACK;
							if (!guardSeen_q) begin
								sdaOe_q <= 1'b1;
								pageData_q[addr_q[1:0]] <= shift_q;
								pageMask_q[addr_q[1:0]] <= 1'b1;
								addr_q[1:0] <= addr_q[1:0] + 2'h1;
							end
						end
					end
				end
				ST_ADDR_ACK: begin
					if (fallEv) begin
						sdaOe_q <= 1'b0;
						// read data output is not part of this block
						state_q <= (rwBit_q == RW_READ) ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA_ACK: begin
					if (fallEv) begin
						sdaOe_q <= 1'b0;
						state_q <= ST_DATA;
					end
				end
			endcase
		end
	end

	// ************************************************
	// storage array
	// ************************************************
	logic [DATA_W-1:0] mem_q [MEM_WORDS];
	logic [DATA_W-1:0] peekData_q;
	logic progBusy_q;
	logic sdaOut_q;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < MEM_WORDS; i++) begin
				mem_q[i] <= MEM_RESET;
			end
		end else if (state_q == ST_PROG && progDone) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (pageMask_q[i]) begin
					mem_q[{addr_q[6:2], 2'(i)}] <= pageData_q[i];
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			peekData_q <= MEM_RESET;
			progBusy_q <= 1'b0;
			sdaOut_q <= 1'b0;
		end else begin
			peekData_q <= mem_q[peekAddr];
			progBusy_q <= (state_q == ST_PROG);
			sdaOut_q <= 1'b0;
		end
	end

	assign sdaOut = sdaOut_q;
	assign sdaOe = sdaOe_q;
	assign progBusy = progBusy_q;
	assign peekData = peekData_q;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	AST_OE_ONLY_IN_ACK: assert property (
		sdaOe_q |-> (state_q == ST_ADDR_ACK || state_q == ST_DATA_ACK))
		else $error("data line driven outside an acknowledge slot");
	AST_ADDR_ACK: assert property (
		(state_q == ST_ADDR && fallEv && bitCnt_q == BITS_PER_BYTE && !startEv && !stopEv)
		|=> sdaOe_q && state_q == ST_ADDR_ACK)
		else $error("address byte not acknowledged");
	AST_WRITE_GOES_DATA: assert property (
		(state_q == ST_ADDR_ACK && fallEv && !rwBit_q && !startEv && !stopEv)
		|=> state_q == ST_DATA && !sdaOe_q)
		else $error("write address did not lead to data phase");
	AST_GUARD_SEEN: assert property (
		(state_q == ST_ADDR && filt_q[WG_I]) |=> guardSeen_q)
		else $error("guard level during address not recorded");
	AST_PROTECTED_NO_ACK: assert property (
		(state_q == ST_DATA_ACK && guardSeen_q) |-> !sdaOe_q && pageMask_q == '0)
		else $error("protected write acknowledged or latched");
	AST_ROW_WRAP: assert property (
		(state_q == ST_DATA && fallEv && bitCnt_q == BITS_PER_BYTE && !guardSeen_q
			&& !startEv && !stopEv)
		|=> addr_q[6:2] == $past(addr_q[6:2]) && addr_q[1:0] == $past(addr_q[1:0]) + 2'h1)
		else $error("address step left the row or missed");
	AST_STOP_PROGRAMS: assert property (
		(stopEv && (state_q == ST_DATA || state_q == ST_DATA_ACK) && |pageMask_q && !guardSeen_q)
		|=> state_q == ST_PROG)
		else $error("stop after write did not start programming");
	AST_PROG_DEAF: assert property (
		(state_q == ST_PROG && !progDone) |=> state_q == ST_PROG && !sdaOe_q)
		else $error("program cycle left early or bus answered");
	AST_PROG_END: assert property (
		(state_q == ST_PROG && progDone) |=> state_q == ST_IDLE ##1 !progBusy_q)
		else $error("program cycle did not end on count");
endmodule // twe_eeprom_slave

// >>> twe_master_model.sv
// two-wire bus master model that drives the clock and data lines
`timescale 1ns/100ps
module twe_master_model #(
	parameter int HALF_NS = 64
) (
	output logic scl,
	output logic sdaDrv,
	input wire logic sdaLine
);
	// the clock idles high and stands still between frames
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	task automatic pulse();
		#HALF_NS scl = 1'b1;
		#HALF_NS scl = 1'b0;
	endtask
	task automatic start();
		// step off the system clock edge the caller waited on, so pins never move on it
		#1;
		sdaDrv = 1'b1;
		#HALF_NS scl = 1'b1;
		#HALF_NS sdaDrv = 1'b0;
		#HALF_NS scl = 1'b0;
	endtask
	task automatic stop();
		sdaDrv = 1'b0;
		#HALF_NS scl = 1'b1;
		#HALF_NS sdaDrv = 1'b1;
		#HALF_NS;
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sdaDrv = b[i];
			pulse();
		end
		// released line reads high through the pull-up unless the device pulls it
		sdaDrv = 1'b1;
		#HALF_NS scl = 1'b1;
		ack = ~sdaLine;
		#HALF_NS scl = 1'b0;
	endtask
endmodule // twe_master_model

// >>> two_wire_eeprom_write_path_tb.sv
// self-checking bench of the eeprom write path
`timescale 1ns/100ps
module two_wire_eeprom_write_path_tb;
	import twe_pkg::*;
	logic clock, sys_rst, writeGuard, sdaOut, sdaOe, progBusy, scl, sdaDrv;
	logic [ADDR_W-1:0] peekAddr;
	logic [DATA_W-1:0] peekData;
	wire logic sda = sdaDrv & (~sdaOe | sdaOut);
	int errorCnt = 0;
	int checksDone = 0;
	// short program time keeps the run small but still outlasts one poll
	twe_eeprom_slave #(.PROG_CYCLES(1000)) dut_u (.clock(clock), .sys_rst(sys_rst),
		.sclClk(scl), .sclIn(scl), .sdaIn(sda), .writeGuard(writeGuard),
		.peekAddr(peekAddr), .sdaOut(sdaOut), .sdaOe(sdaOe), .progBusy(progBusy),
		.peekData(peekData));
	twe_master_model mdl_u (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sda));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic close_out();
		if (errorCnt == 0 && checksDone > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		checksDone++;
		if (got !== exp) begin
			errorCnt++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (progBusy !== lvl && n < 2000) begin
			@(posedge clock);
			n++;
		end
		if (n >= 2000) begin
			errorCnt++;
			close_out();
		end
	endtask
	task automatic peek(input logic [6:0] a, input logic [7:0] exp);
		@(posedge clock) peekAddr <= a;
		repeat (3) @(posedge clock);
		chk(exp, peekData);
	endtask
	task automatic xfer(input logic [7:0] ab, input logic [39:0] dv, input int n,
		input logic expAck);
		logic a;
		mdl_u.start();
		mdl_u.send(ab, a);
		chk(8'h01, {7'h0, a});
		chk(8'h00, {7'h0, sdaOut});
		for (int i = 0; i < n; i++) begin
			mdl_u.send(dv[39 - 8 * i -: 8], a);
			chk({7'h0, expAck}, {7'h0, a});
		end
		mdl_u.stop();
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic byte_write();
		logic a;
		xfer(8'h26, 40'h5a00000000, 1, 1'b1);
		wait_busy(1'b1);
		mdl_u.start();
		mdl_u.send(8'h26, a);
		chk(8'h00, {7'h0, a});
		mdl_u.stop();
		wait_busy(1'b0);
		peek(7'h13, 8'h5a);
	endtask
	task automatic page_wrap();
		logic [31:0] exp;
		exp = 32'ha2a3a4a1;
		xfer(8'h3c, 40'ha0a1a2a3a4, 5, 1'b1);
		wait_busy(1'b1);
		wait_busy(1'b0);
		for (int i = 0; i < 4; i++)
			peek(7'h1c + 7'(i), exp[31 - 8 * i -: 8]);
	endtask
	task automatic guarded_write();
		@(posedge clock) writeGuard <= 1'b1;
		xfer(8'h40, 40'h1100000000, 1, 1'b0);
		@(posedge clock) writeGuard <= 1'b0;
		repeat (40) @(posedge clock);
		chk(8'h00, {7'h0, progBusy});
		peek(7'h20, MEM_RESET);
	endtask
	task automatic read_dir();
		xfer(8'h4f, 40'h0, 0, 1'b1);
		repeat (40) @(posedge clock);
		chk(8'h00, {7'h0, progBusy});
	endtask
	initial begin
		sys_rst = 1'b1;
		writeGuard = 1'b0;
		peekAddr = 7'h0;
		// bus stays idle through reset, as the link side needs
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (10) @(posedge clock);
		byte_write();
		page_wrap();
		guarded_write();
		read_dir();
		close_out();
	end
endmodule // two_wire_eeprom_write_path_tb
